// ===== verilog/pchr_pkg.sv
// Package: offsets, field layouts, reset values and states of the capability header registers
package pchr_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned PCHR_ADDR_W = 12;
  localparam int unsigned PCHR_DATA_W = 32;
  localparam int unsigned PCHR_STRB_W = 4;
  localparam int unsigned PCHR_WORD_LSB = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] PCHR_OFF_HEADER = 12'h040;
  localparam logic [11:0] PCHR_OFF_DEVCAP = 12'h044;
  localparam logic [11:0] PCHR_OFF_CONTROL = 12'h050;
  localparam logic [11:0] PCHR_OFF_STATUS = 12'h054;

  // ****************************************************************
  // Header fields and values
  // ****************************************************************
  localparam logic [7:0] PCHR_CAP_KIND_CODE = 8'h10;
  localparam logic [7:0] PCHR_NEXT_PTR_RST = 8'hc0;
  localparam logic [3:0] PCHR_VERSION_RST = 4'h1;
  localparam logic [3:0] PCHR_TYPE_UPSTREAM = 4'h5;
  localparam logic [3:0] PCHR_TYPE_DOWNSTREAM = 4'h6;
  localparam logic PCHR_SLOT_RST = 1'b0;
  localparam logic [4:0] PCHR_MSI_INDEX = 5'h00;
  localparam logic PCHR_TC_ROUTING_RST = 1'b1;
  localparam logic [31:0] PCHR_HDR_LOAD_MASK = 32'h410f_ff00;

  // ****************************************************************
  // Device capabilities fields and values
  // ****************************************************************
  localparam logic [2:0] PCHR_MPS_RST = 3'h1;
  localparam logic [1:0] PCHR_PHANTOM = 2'h0;
  localparam logic PCHR_EXTENDED_TAG_SUPPORT_RST = 1'b1;
  localparam logic [2:0] PCHR_L0S_LAT = 3'h0;
  localparam logic [2:0] PCHR_L1_LAT = 3'h0;
  localparam logic [2:0] PCHR_INDICATORS = 3'h0;
  localparam logic PCHR_ROLE_ERR = 1'b1;
  localparam logic [31:0] PCHR_DCAP_LOAD_MASK = 32'h0000_0027;

  // ****************************************************************
  // Own control and status bits
  // ****************************************************************
  localparam int unsigned PCHR_CTRL_LOAD_EN_BIT = 0;
  localparam int unsigned PCHR_STS_STRAP_DONE_BIT = 0;
  localparam int unsigned PCHR_STS_UPSTREAM_BIT = 1;
  localparam int unsigned PCHR_STS_CAPTURED_BIT = 2;

  // ****************************************************************
  // Strap capture states, Gray along the path
  // ****************************************************************
  typedef enum logic [1:0] {
    PCHR_ST_SYNC0 = 2'b00,
    PCHR_ST_SYNC1 = 2'b01,
    PCHR_ST_SYNC2 = 2'b11,
    PCHR_ST_DONE = 2'b10
  } pchr_strap_state_t;

endpackage : pchr_pkg

// ===== verilog/pchr_slot_power_capture.sv
// Capture of slot power value and scale from a received power limit message
module pchr_slot_power_capture
  import pchr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture_enable,
  input wire logic msg_valid,
  input wire logic [7:0] msg_value,
  input wire logic [1:0] msg_scale,
  output logic [7:0] value_reg,
  output logic [1:0] scale_reg,
  output logic captured_reg
);

  logic [7:0] value_next;
  logic [1:0] scale_next;
  logic captured_next;

  // ****************************************************************
  // Capture
  // ****************************************************************
  always_comb begin
    value_next = value_reg;
    scale_next = scale_reg;
    captured_next = 1'b0;
    // Downstream ports never leave zero
    if (capture_enable && msg_valid) begin
      value_next = msg_value;
      scale_next = msg_scale;
      captured_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_reg <= 8'h00;
      scale_reg <= 2'h0;
      captured_reg <= 1'b0;
    end else begin
      value_reg <= value_next;
      scale_reg <= scale_next;
      captured_reg <= captured_next;
    end
  end

endmodule : pchr_slot_power_capture

// ===== verilog/pchr_regs.sv
// Capability header and device capabilities registers of one switch port, APB slave
//
// Overview of operation
// - The low byte of the header always reads the fixed capability kind code 0x10.
// - Header bits 15:8 hold the next structure pointer, reset 0xc0, loadable only.
// - Header bits 19:16 hold the structure version, reset 1, loadable only.
// - Header bits 23:20 read 5 on the upstream port and 6 on a downstream port.
// - Header bits 29:25, the interrupt vector index, always read zero.
// - Header bit 30 advertises class based routing, reset 1, loadable.
// - Capability bits 2:0 give maximum payload supported, reset code 1, loadable.
// - Capability bits 4:3 for phantom functions are hardwired to zero.
// - Capability bit 5 reports extended tag support, reset 1, loadable.
// - Capability bits 8:6, the L0s latency, read a hardwired zero.
// - Capability bits 11:9, the L1 latency, read a hardwired zero.
// - Capability bits 12, 13 and 14 are read-only zero.
// - Capability bit 15 reads one for role based error reporting.
// - Bits 25:18 capture the message power value on the upstream port only.
// - Bits 27:26 capture the message power scale on the upstream port only.
module pchr_regs
  import pchr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_upstream_strap,
  input wire logic power_msg_valid,
  input wire logic [7:0] power_msg_value,
  input wire logic [1:0] power_msg_scale,
  output logic port_is_upstream,
  output logic [2:0] max_payload_supported,
  output logic extended_tag_support,
  output logic traffic_class_routing_flag,
  output logic [7:0] slot_power_value,
  output logic [1:0] slot_power_scale
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic strap_q1_reg;
  logic strap_q2_reg;
  pchr_strap_state_t state_reg;
  pchr_strap_state_t state_next;
  logic upstream_reg;
  logic upstream_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [7:0] next_structure_pointer_reg;
  logic [7:0] next_structure_pointer_next;
  logic [3:0] structure_version_reg;
  logic [3:0] structure_version_next;
  logic slot_flag_reg;
  logic slot_flag_next;
  logic traffic_class_routing_flag_reg;
  logic traffic_class_routing_flag_next;
  logic [2:0] max_payload_supported_reg;
  logic [2:0] max_payload_supported_next;
  logic extended_tag_support_reg;
  logic extended_tag_support_next;
  logic load_enable_reg;
  logic load_enable_next;
  logic captured_seen_reg;
  logic captured_seen_next;
  logic [7:0] cap_value;
  logic [1:0] cap_scale;
  logic cap_pulse;
  logic access_phase;
  logic first_access;
  logic complete;
  logic hit_header;
  logic hit_devcap;
  logic hit_control;
  logic hit_status;
  logic hit_any;
  logic apb_write;
  logic [31:0] byte_mask;
  logic [31:0] header_image;
  logic [31:0] devcap_image;
  logic [31:0] control_image;
  logic [31:0] status_image;
  logic [31:0] header_written;
  logic [31:0] devcap_written;
  logic [31:0] read_data;
  logic [3:0] port_type_code;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    reg_hit = (addr[11:PCHR_WORD_LSB] == offset[11:PCHR_WORD_LSB]);
  endfunction : reg_hit
  function automatic logic [31:0] merge_write(input logic [31:0] old_value,
                                              input logic [31:0] wdata,
                                              input logic [31:0] mask);
    merge_write = (old_value & ~mask) | (wdata & mask);
  endfunction : merge_write
  // ****************************************************************
  // Port strap, caught after reset release
  // ****************************************************************
  // Strap is a pin; two flops before the capture state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q1_reg <= 1'b0;
      strap_q2_reg <= 1'b0;
    end else begin
      strap_q1_reg <= port_upstream_strap;
      strap_q2_reg <= strap_q1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    upstream_next = upstream_reg;
    unique case (state_reg)
      PCHR_ST_SYNC0: begin
        state_next = PCHR_ST_SYNC1;
      end
      PCHR_ST_SYNC1: begin
        state_next = PCHR_ST_SYNC2;
      end
      PCHR_ST_SYNC2: begin
        upstream_next = strap_q2_reg;
        state_next = PCHR_ST_DONE;
      end
      PCHR_ST_DONE: begin
        state_next = PCHR_ST_DONE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PCHR_ST_SYNC0;
      upstream_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      upstream_reg <= upstream_next;
    end
  end
  // Port type fixed once the strap is in
  assign port_type_code = upstream_reg ? PCHR_TYPE_UPSTREAM : PCHR_TYPE_DOWNSTREAM;
  // ****************************************************************
  // Slot power capture
  // ****************************************************************
  pchr_slot_power_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .capture_enable(upstream_reg && (state_reg == PCHR_ST_DONE)),
    .msg_valid(power_msg_valid),
    .msg_value(power_msg_value),
    .msg_scale(power_msg_scale),
    .value_reg(cap_value),
    .scale_reg(cap_scale),
    .captured_reg(cap_pulse)
  );

  // ****************************************************************
  // Register images
  // ****************************************************************
  assign header_image = {
    1'b0,
    traffic_class_routing_flag_reg,
    PCHR_MSI_INDEX,
    slot_flag_reg,
    port_type_code,
    structure_version_reg,
    next_structure_pointer_reg,
    PCHR_CAP_KIND_CODE
  };

  assign devcap_image = {
    4'h0,
    cap_scale,
    cap_value,
    2'h0,
    PCHR_ROLE_ERR,
    PCHR_INDICATORS,
    PCHR_L1_LAT,
    PCHR_L0S_LAT,
    extended_tag_support_reg,
    PCHR_PHANTOM,
    max_payload_supported_reg
  };

  assign control_image = {31'h0000_0000, load_enable_reg};
  assign status_image = {29'h0000_0000, captured_seen_reg, upstream_reg,
                         (state_reg == PCHR_ST_DONE)};

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign access_phase = psel && penable;
  assign first_access = access_phase && !pready_reg;
  assign complete = access_phase && pready_reg;
  assign hit_header = reg_hit(paddr, PCHR_OFF_HEADER);
  assign hit_devcap = reg_hit(paddr, PCHR_OFF_DEVCAP);
  assign hit_control = reg_hit(paddr, PCHR_OFF_CONTROL);
  assign hit_status = reg_hit(paddr, PCHR_OFF_STATUS);
  assign hit_any = hit_header || hit_devcap || hit_control || hit_status;
  assign apb_write = complete && pwrite && hit_any;

  for (genvar b = 0; b < PCHR_STRB_W; b++) begin : g_byte_mask
    assign byte_mask[b*8 +: 8] = {8{pstrb[b]}};
  end

  // Only loadable bits pass; fixed and reserved bits never change
  assign header_written = merge_write(header_image, pwdata,
                                      byte_mask & PCHR_HDR_LOAD_MASK);
  assign devcap_written = merge_write(devcap_image, pwdata,
                                      byte_mask & PCHR_DCAP_LOAD_MASK);

  always_comb begin
    read_data = 32'h0000_0000;
    if (hit_header) begin
      read_data = header_image;
    end else if (hit_devcap) begin
      read_data = devcap_image;
    end else if (hit_control) begin
      read_data = control_image;
    end else if (hit_status) begin
      read_data = status_image;
    end
  end

  // ****************************************************************
  // APB answer, one wait state
  // ****************************************************************
  always_comb begin
    pready_next = first_access;
    pslverr_next = first_access && !hit_any;
    prdata_next = (first_access && !pwrite) ? read_data : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  // ****************************************************************
  // Loadable fields
  // ****************************************************************
  // Loading is gated by the control bit so ordinary writes cannot disturb the image
  always_comb begin
    next_structure_pointer_next = next_structure_pointer_reg;
    structure_version_next = structure_version_reg;
    slot_flag_next = slot_flag_reg;
    traffic_class_routing_flag_next = traffic_class_routing_flag_reg;
    max_payload_supported_next = max_payload_supported_reg;
    extended_tag_support_next = extended_tag_support_reg;
    load_enable_next = load_enable_reg;
    if (apb_write && hit_header && load_enable_reg) begin
      next_structure_pointer_next = header_written[15:8];
      structure_version_next = header_written[19:16];
      // Loader keeps this clear on the upstream port
      slot_flag_next = header_written[24];
      traffic_class_routing_flag_next = header_written[30];
    end
    if (apb_write && hit_devcap && load_enable_reg) begin
      max_payload_supported_next = devcap_written[2:0];
      extended_tag_support_next = devcap_written[5];
    end
    if (apb_write && hit_control && pstrb[0]) begin
      load_enable_next = pwdata[PCHR_CTRL_LOAD_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_structure_pointer_reg <= PCHR_NEXT_PTR_RST;
      structure_version_reg <= PCHR_VERSION_RST;
      slot_flag_reg <= PCHR_SLOT_RST;
      traffic_class_routing_flag_reg <= PCHR_TC_ROUTING_RST;
      max_payload_supported_reg <= PCHR_MPS_RST;
      extended_tag_support_reg <= PCHR_EXTENDED_TAG_SUPPORT_RST;
      load_enable_reg <= 1'b0;
    end else begin
      next_structure_pointer_reg <= next_structure_pointer_next;
      structure_version_reg <= structure_version_next;
      slot_flag_reg <= slot_flag_next;
      traffic_class_routing_flag_reg <= traffic_class_routing_flag_next;
      max_payload_supported_reg <= max_payload_supported_next;
      extended_tag_support_reg <= extended_tag_support_next;
      load_enable_reg <= load_enable_next;
    end
  end

  // ****************************************************************
  // Capture seen flag
  // ****************************************************************
  // Set beats clear so a message landing on the clear is not lost
  always_comb begin
    captured_seen_next = captured_seen_reg;
    if (apb_write && hit_status && pstrb[0] && pwdata[PCHR_STS_CAPTURED_BIT]) begin
      captured_seen_next = 1'b0;
    end
    if (cap_pulse) begin
      captured_seen_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_seen_reg <= 1'b0;
    end else begin
      captured_seen_reg <= captured_seen_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_is_upstream = upstream_reg;
  assign max_payload_supported = max_payload_supported_reg;
  assign extended_tag_support = extended_tag_support_reg;
  assign traffic_class_routing_flag = traffic_class_routing_flag_reg;
  assign slot_power_value = cap_value;
  assign slot_power_scale = cap_scale;

endmodule : pchr_regs

// ===== dv/pchr_regs_chk.sv
// Checker: port-level properties of the capability header registers
module pchr_regs_chk
  import pchr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_msg_valid,
  input wire logic [7:0] power_msg_value,
  input wire logic [1:0] power_msg_scale,
  input wire logic port_is_upstream,
  input wire logic [2:0] max_payload_supported,
  input wire logic extended_tag_support,
  input wire logic traffic_class_routing_flag,
  input wire logic [7:0] slot_power_value,
  input wire logic [1:0] slot_power_scale
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd_hdr;
  logic rd_dcap;
  logic mapped;
  assign rd_hdr = pready && !pwrite && paddr[11:2] == 10'h010;
  assign rd_dcap = pready && !pwrite && paddr[11:2] == 10'h011;
  assign mapped = paddr[11:2] inside {10'h010, 10'h011, 10'h014, 10'h015};
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  a_ready_one_wait: assert property (s_setup |=> s_one_wait) else $error("pready timing");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0) else $error("prdata not 0");
  a_hdr_fixed: assert property (rd_hdr |-> prdata[7:0] == 8'h10 && prdata[31:25] ==
    {1'b0, traffic_class_routing_flag, 5'h00} && prdata[23:20] == (port_is_upstream ?
    4'h5 : 4'h6)) else $error("header fixed fields");
  a_dcap_fixed: assert property (rd_dcap |->
    {prdata[31:28], prdata[17:6], prdata[4:3]} == {4'h0, 12'h200, 2'h0} &&
    prdata[2:0] == max_payload_supported && prdata[5] == extended_tag_support &&
    prdata[27:18] == {slot_power_scale, slot_power_value}) else $error("device caps fields");
  a_down_no_power: assert property (!port_is_upstream |->
    {slot_power_scale, slot_power_value} == 10'h0) else $error("downstream power set");
  a_msg_capture: assert property (power_msg_valid && port_is_upstream |=>
    slot_power_value == $past(power_msg_value) && slot_power_scale == $past(power_msg_scale))
    else $error("message not captured");
  a_power_hold: assert property (!power_msg_valid |=> $stable(slot_power_value) &&
    $stable(slot_power_scale)) else $error("power changed");
endmodule : pchr_regs_chk

bind pchr_regs pchr_regs_chk u_chk (.*);

// ===== dv/pchr_regs_test.sv
// Testbench: register reads, loads, refusals and power messages
module pchr_regs_test;
  import pchr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, strap = 1'b0;
  logic msg_v = 1'b0;
  logic [7:0] msg_val = 8'h0, pv;
  logic [1:0] msg_sc = 2'h0, ps;
  logic up_o, extended_tag_support_o, tc_o;
  logic [2:0] mps_o;
  logic [7:0] spv_o;
  logic [1:0] sps_o;
  logic [31:0] lfsr = 32'hb569, hl, dl, rd, m, wd;
  logic [11:0] bad_addr [4] = '{12'h000, 12'h048, 12'h03c, 12'hffc};
  logic up, err;
  int bad_count = 0, num_checks = 0;
  always #2 pclk = ~pclk;
  pchr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_upstream_strap(strap),
    .power_msg_valid(msg_v), .power_msg_value(msg_val), .power_msg_scale(msg_sc),
    .port_is_upstream(up_o), .max_payload_supported(mps_o), .extended_tag_support(extended_tag_support_o),
    .traffic_class_routing_flag(tc_o), .slot_power_value(spv_o), .slot_power_scale(sps_o));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  function automatic logic [31:0] exp_hdr();
    return hl | {8'h00, (up ? 4'h5 : 4'h6), 12'h000, 8'h10};
  endfunction : exp_hdr
  function automatic logic [31:0] exp_dcap();
    return dl | {4'h0, ps, pv, 18'h08000};
  endfunction : exp_dcap
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  // Waits on pready, never assumes the wait state count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic check_all();
    apb(1'b0, 12'h040, 32'h0, 4'h0);
    check(rd, exp_hdr());
    check({31'h0, err}, 32'h0);
    apb(1'b0, 12'h044, 32'h0, 4'h0);
    check(rd, exp_dcap());
    check({mps_o, extended_tag_support_o, tc_o, sps_o, spv_o, up_o},
          {dl[2:0], dl[5], hl[30], ps, pv, up});
  endtask : check_all
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    up = s;
    hl = 32'h4001_c000;
    dl = 32'h0000_0021;
    pv = 8'h0;
    ps = 2'h0;
  endtask : do_reset
  // Same-clock pulses, back to back; the last one stands
  task automatic send_msgs(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      @(posedge pclk);
      lfsr = nxt(lfsr);
      msg_v <= 1'b1;
      msg_val <= lfsr[7:0];
      msg_sc <= 2'(i);
      if (up) begin
        pv = lfsr[7:0];
        ps = 2'(i);
      end
    end
    @(posedge pclk);
    msg_v <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : send_msgs
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (50000) @(posedge pclk);
    bad_count++;
    results();
  end
  initial begin
    for (int p = 0; p < 2; p++) begin
      do_reset(p[0]);
      check_all();
      // Loads refused while load enable is off
      apb(1'b1, 12'h040, 32'hffff_ffff, 4'hf);
      apb(1'b1, 12'h044, 32'hffff_ffff, 4'hf);
      check_all();
      send_msgs(4);
      check_all();
      // Capture flag set only upstream, then write one to clear
      apb(1'b0, 12'h054, 32'h0, 4'h0);
      check(rd, {29'h0, up, up, 1'b1});
      apb(1'b1, 12'h054, 32'h4, 4'h1);
      apb(1'b0, 12'h054, 32'h0, 4'h0);
      check(rd, {30'h0, up, 1'b1});
      apb(1'b1, 12'h050, 32'h1, 4'hf);
      apb(1'b0, 12'h050, 32'h0, 4'h0);
      check(rd, 32'h1);
      for (int i = 0; i < 12; i++) begin
        lfsr = nxt(lfsr);
        m = {{8{lfsr[3]}}, {8{lfsr[2]}}, {8{lfsr[1]}}, {8{lfsr[0]}}};
        wd = nxt(lfsr);
        if (i == 0) m = 32'hffff_ffff;
        if (i == 0) wd = 32'hffff_ffff;
        // Loader keeps the slot flag clear on the upstream port
        if (up) wd[24] = 1'b0;
        // Reserved bits take nothing even with load enable on
        apb(1'b1, 12'h040, wd, lfsr[3:0] | {4{i == 0}});
        hl = (hl & ~(m & 32'h410f_ff00)) | (wd & m & 32'h410f_ff00);
        apb(1'b1, 12'h044, ~wd, lfsr[3:0] | {4{i == 0}});
        dl = (dl & ~(m & 32'h27)) | (~wd & m & 32'h27);
        check_all();
      end
      foreach (bad_addr[k]) begin
        apb(k[0], bad_addr[k], 32'hffff_ffff, 4'hf);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
      end
      check_all();
    end
    results();
  end
endmodule : pchr_regs_test
